/* File: logic/sac_regs.svh */
// Register map, field positions, reset values and timing counts of the converter control.
// Assumes a 20-bit Wishbone byte address and a 200 MHz system clock.
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

`define SAC_OFS_PER_EN 20'hf00f0
`define SAC_OFS_CTRL 20'hf0100
`define SAC_OFS_MODE3 20'hf0104
`define SAC_OFS_CHAN 20'hf0108
`define SAC_OFS_APC 20'hf010c
`define SAC_OFS_WIDE 20'hf0110
`define SAC_OFS_NARROW 20'hf0114
`define SAC_OFS_STATUS 20'hf0118

`define SAC_PER_RESET 8'h00
`define SAC_PER_MASK 8'hbd
`define SAC_PER_CONVERTER_CLOCK_ENABLE 5

`define SAC_CTRL_RESET 2'h0
`define SAC_CTRL_RUN 0
`define SAC_CTRL_ONESHOT 1

`define SAC_MODE3_RESET 4'h0
`define SAC_MODE3_RES8 0
`define SAC_MODE3_MREF 1
`define SAC_MODE3_PREF_LO 2
`define SAC_MODE3_PREF_HI 3

`define SAC_CHAN_RESET 2'h0
`define SAC_APC_RESET 4'h0

`define SAC_MSB_IDX 4'h9
`define SAC_STOP10_IDX 4'h0
`define SAC_STOP8_IDX 4'h2

`define SAC_CLK_MHZ 200
`define SAC_SAMPLE_NS 100
`define SAC_TRIAL_NS 50
`define SAC_SAMPLE_CYC ((`SAC_SAMPLE_NS * `SAC_CLK_MHZ + 999) / 1000)
`define SAC_TRIAL_CYC ((`SAC_TRIAL_NS * `SAC_CLK_MHZ + 999) / 1000)

`endif

/* File: logic/sac_pkg.sv */
// Types shared by the converter control files.
// Assumes the constants header is included by the users of this package.
package sac_pkg;
	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_SAMPLE = 2'b01,
		SAC_TRIAL = 2'b11,
		SAC_DONE = 2'b10
	} sac_state_e;
endpackage

/* File: logic/sac_result_store.sv */
// Wide and narrow conversion result holding registers.
// Assumes rst_i is the synchronous converter reset, including the clock-enable gate.
`timescale 1ns/1ps
module sac_result_store import sac_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [9:0] data_i,
	output logic [15:0] wide_o,
	output logic [7:0] narrow_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wide_o <= 16'h0000;
			narrow_o <= 8'h00;
		end else if (load_i) begin
			wide_o <= {data_i, 6'h00};
			narrow_o <= data_i[9:2];
		end
	end
endmodule

/* File: logic/sac_top.sv */
// Successive-approximation converter control with a classic Wishbone register slave.
// Assumes the analog front end presents cmp_ge_i synchronous to clk_i, settled
// within one trial window after tap_code_o changes.
//
// How it works
// - First trial against half reference sets MSB
// - Bit 8 trial tap chosen from bit 9
// - Trial bit kept when input at or above tap
// - 10-bit mode decides bits down to bit 0
// - 8-bit mode stops after bit 2
// - Wide result holds 10 bits high, six zeros
// - Narrow result holds upper 8 result bits
// - Done request raised when conversion finished
// - Enable low stops clock, holds converter reset
// - Enable low: converter writes ignored, reads give defaults; port configuration stays live
// - Enable high: converter registers read and write
// - System reset clears peripheral enable to zero
// - Peripheral enable written by bit or byte
// - Unselected analog pins stay general purpose
// - Both plus select bits pick external reference
// - Minus select bit picks external minus reference
// - Resolution bit chooses 10-bit or 8-bit end
// - One-shot mode clears run bit at end
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "sac_regs.svh"
module sac_top import sac_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [19:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic cmp_ge_i,
	output logic sample_hold_o,
	output logic [9:0] tap_code_o,
	output logic plus_ref_external_o,
	output logic plus_ref_internal_o,
	output logic minus_ref_external_o,
	output logic [7:0] periph_clock_enable_o,
	output logic [3:0] analog_select_o,
	output logic [3:0] port_free_o,
	output logic conversion_done_irq_o
);
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [4:0] SAMPLE_LOAD = 5'(`SAC_SAMPLE_CYC - 1);
	localparam logic [4:0] TRIAL_LOAD = 5'(`SAC_TRIAL_CYC - 1);

	function automatic logic [9:0] bit_mask(input logic [3:0] idx);
		bit_mask = 10'h001 << idx;
	endfunction

	logic [7:0] per_en;
	logic [1:0] ctrl;
	logic [3:0] mode3;
	logic [1:0] chan;
	logic [3:0] apc;
	sac_state_e state;
	sac_state_e next_state;
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic [3:0] bit_idx;
	logic [3:0] next_idx;
	logic [9:0] approximation_register;
	logic [9:0] next_sar;
	logic [15:0] wide_result;
	logic [7:0] narrow_result;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode; ack is registered so every request takes exactly one wait state
	wire req = cyc_i & stb_i & ~ack_o;
	wire wr = req & we_i & sel_i[0];
	wire hit_per = adr_i == `SAC_OFS_PER_EN;
	wire hit_ctrl = adr_i == `SAC_OFS_CTRL;
	wire hit_mode3 = adr_i == `SAC_OFS_MODE3;
	wire hit_chan = adr_i == `SAC_OFS_CHAN;
	wire hit_apc = adr_i == `SAC_OFS_APC;
	wire hit_wide = adr_i == `SAC_OFS_WIDE;
	wire hit_narrow = adr_i == `SAC_OFS_NARROW;
	wire hit_status = adr_i == `SAC_OFS_STATUS;

	wire converter_clock_enable = per_en[`SAC_PER_CONVERTER_CLOCK_ENABLE];
	// Gate off acts as a reset, so gated registers read back their defaults
	wire conv_rst = rst_i | ~converter_clock_enable;
	wire [3:0] stop_idx = mode3[`SAC_MODE3_RES8] ? `SAC_STOP8_IDX : `SAC_STOP10_IDX;
	wire cnt_done = cnt == 5'h00;
	wire trial_end = (state == SAC_TRIAL) & cnt_done & ctrl[`SAC_CTRL_RUN];
	// At or below the stop bit, so a resolution change mid-run cannot wrap the index
	wire final_step = trial_end & (bit_idx <= stop_idx);
	wire [9:0] trial_mask = bit_mask(bit_idx);
	wire [9:0] decided_sar = cmp_ge_i ? (approximation_register | trial_mask) : (approximation_register & ~trial_mask);

	wire sw_ctrl = wr & hit_ctrl;
	// A software write of the run bit beats the automatic clear
	wire next_run = sw_ctrl ? dat_i[`SAC_CTRL_RUN] :
		((final_step & ctrl[`SAC_CTRL_ONESHOT]) ? 1'b0 : ctrl[`SAC_CTRL_RUN]);
	wire next_oneshot = sw_ctrl ? dat_i[`SAC_CTRL_ONESHOT] : ctrl[`SAC_CTRL_ONESHOT];
	wire [3:0] chan_onehot = 4'h1 << chan;
	wire [31:0] status_word = {18'h00000, approximation_register, 3'h0, state != SAC_IDLE};

	wire [31:0] rd_word = hit_per ? {24'h000000, per_en} :
		hit_ctrl ? {30'h00000000, ctrl} :
		hit_mode3 ? {28'h0000000, mode3} :
		hit_chan ? {30'h00000000, chan} :
		hit_apc ? {28'h0000000, apc} :
		hit_wide ? {16'h0000, wide_result} :
		hit_narrow ? {24'h000000, narrow_result} :
		hit_status ? status_word : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			dat_o <= req ? rd_word : 32'h00000000;
		end
	end

	// Bit writes arrive as a full byte; reserved bits are forced to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			per_en <= `SAC_PER_RESET;
		end else if (wr & hit_per) begin
			per_en <= dat_i[7:0] & `SAC_PER_MASK;
		end
	end

	// Port configuration stays live while the converter is gated off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			apc <= `SAC_APC_RESET;
		end else if (wr & hit_apc) begin
			apc <= dat_i[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (conv_rst) begin
			ctrl <= `SAC_CTRL_RESET;
			mode3 <= `SAC_MODE3_RESET;
			chan <= `SAC_CHAN_RESET;
		end else begin
			ctrl <= {next_oneshot, next_run};
			if (wr & hit_mode3) begin
				mode3 <= dat_i[3:0];
			end
			if (wr & hit_chan) begin
				chan <= dat_i[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_cnt = cnt_done ? 5'h00 : cnt - 5'h01;
		next_idx = bit_idx;
		next_sar = approximation_register;
		unique case (state)
			SAC_IDLE: begin
				if (ctrl[`SAC_CTRL_RUN]) begin
					next_state = SAC_SAMPLE;
					next_cnt = SAMPLE_LOAD;
				end
			end
			SAC_SAMPLE: begin
				if (!ctrl[`SAC_CTRL_RUN]) begin
					next_state = SAC_IDLE;
				end else if (cnt_done) begin
					next_state = SAC_TRIAL;
					next_cnt = TRIAL_LOAD;
					next_idx = `SAC_MSB_IDX;
					next_sar = 10'h000;
				end
			end
			SAC_TRIAL: begin
				if (!ctrl[`SAC_CTRL_RUN]) begin
					next_state = SAC_IDLE;
				end else if (cnt_done) begin
					next_sar = decided_sar;
					if (final_step) begin
						next_state = SAC_DONE;
					end else begin
						next_idx = bit_idx - 4'h1;
						next_cnt = TRIAL_LOAD;
					end
				end
			end
			SAC_DONE: begin
				if (ctrl[`SAC_CTRL_RUN]) begin
					next_state = SAC_SAMPLE;
					next_cnt = SAMPLE_LOAD;
				end else begin
					next_state = SAC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (conv_rst) begin
			state <= SAC_IDLE;
			cnt <= 5'h00;
			bit_idx <= `SAC_MSB_IDX;
			approximation_register <= 10'h000;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			bit_idx <= next_idx;
			approximation_register <= next_sar;
		end
	end

	// Tap code: decided bits plus the tentative trial bit
	always_ff @(posedge clk_i) begin
		if (conv_rst) begin
			tap_code_o <= 10'h000;
			sample_hold_o <= 1'b0;
			conversion_done_irq_o <= 1'b0;
		end else begin
			tap_code_o <= (next_state == SAC_TRIAL) ? (next_sar | bit_mask(next_idx)) : 10'h000;
			sample_hold_o <= next_state == SAC_SAMPLE;
			conversion_done_irq_o <= final_step;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			plus_ref_external_o <= 1'b0;
			plus_ref_internal_o <= 1'b0;
			minus_ref_external_o <= 1'b0;
			analog_select_o <= 4'h0;
			port_free_o <= 4'hf;
		end else begin
			plus_ref_external_o <= mode3[`SAC_MODE3_PREF_HI] & mode3[`SAC_MODE3_PREF_LO];
			plus_ref_internal_o <= ~mode3[`SAC_MODE3_PREF_HI] & mode3[`SAC_MODE3_PREF_LO];
			minus_ref_external_o <= mode3[`SAC_MODE3_MREF];
			analog_select_o <= converter_clock_enable ? (chan_onehot & apc) : 4'h0;
			port_free_o <= converter_clock_enable ? ~(chan_onehot & apc) : 4'hf;
		end
	end

	assign periph_clock_enable_o = per_en;

	sac_result_store u_result (
		.clk_i(clk_i),
		.rst_i(conv_rst),
		.load_i(final_step),
		.data_i(decided_sar),
		.wide_o(wide_result),
		.narrow_o(narrow_result)
	);

	////////////////////////////////////////////////////////////////////////////////
	property p_msb_first;
		@(posedge clk_i) disable iff (conv_rst)
		(state == SAC_SAMPLE && ctrl[`SAC_CTRL_RUN] && cnt_done) |=> (tap_code_o == 10'h200);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("MSB trial not first");

	property p_bit8_tap;
		@(posedge clk_i) disable iff (conv_rst)
		(trial_end && bit_idx == 4'h9 && !final_step) |=>
			(tap_code_o == {approximation_register[9], 9'h100});
	endproperty
	a_bit8_tap: assert property (p_bit8_tap) else $error("Bit 8 tap wrong");

	property p_keep;
		@(posedge clk_i) disable iff (conv_rst)
		trial_end |=> (approximation_register[$past(bit_idx)] == $past(cmp_ge_i));
	endproperty
	a_keep: assert property (p_keep) else $error("Trial bit not decided by compare");

	property p_stop8;
		@(posedge clk_i) disable iff (conv_rst)
		(trial_end && mode3[`SAC_MODE3_RES8] && bit_idx == 4'h2) |=>
			(state == SAC_DONE && approximation_register[1:0] == 2'b00);
	endproperty
	a_stop8: assert property (p_stop8) else $error("8-bit end point wrong");

	property p_stop10;
		@(posedge clk_i) disable iff (conv_rst)
		(trial_end && !mode3[`SAC_MODE3_RES8] && bit_idx != 4'h0) |=> (state == SAC_TRIAL);
	endproperty
	a_stop10: assert property (p_stop10) else $error("10-bit sequence ended early");

	property p_results;
		@(posedge clk_i) disable iff (conv_rst)
		conversion_done_irq_o |-> (wide_result == {approximation_register, 6'h00} && narrow_result == approximation_register[9:2]);
	endproperty
	a_results: assert property (p_results) else $error("Result registers mismatch");

	property p_irq_pulse;
		@(posedge clk_i) disable iff (conv_rst)
		final_step |=> conversion_done_irq_o ##1 !conversion_done_irq_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("Done request not one pulse");

	property p_oneshot;
		@(posedge clk_i) disable iff (conv_rst)
		(final_step && ctrl[`SAC_CTRL_ONESHOT] && !sw_ctrl) |=> !ctrl[`SAC_CTRL_RUN];
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("Run bit not cleared");

	property p_gate;
		@(posedge clk_i) disable iff (rst_i)
		!converter_clock_enable |=> (ctrl == 2'h0 && mode3 == 4'h0 && state == SAC_IDLE && wide_result == 16'h0000);
	endproperty
	a_gate: assert property (p_gate) else $error("Converter not held in reset");

	property p_per_reset;
		@(posedge clk_i)
		rst_i |=> (per_en == 8'h00);
	endproperty
	a_per_reset: assert property (p_per_reset) else $error("Enable register not cleared");
endmodule

/* File: verification/sac_front_end_model.sv */
// Behavioural comparator and sample-and-hold facing the converter control.
// Assumes level_i is in code units of whatever reference is selected.
`timescale 1ns/1ps
module sac_front_end_model (
	input wire logic clk_i,
	input wire logic sample_hold_i,
	input wire logic [9:0] tap_code_i,
	input wire logic [9:0] level_i,
	input wire logic slow_i,
	output logic cmp_ge_o
);
	logic [9:0] held;
	logic [3:0] pipe;
	// Slow mode lags four cycles, still inside one trial window
	always_ff @(posedge clk_i) begin
		if (sample_hold_i) begin
			held <= level_i;
		end
		pipe <= {pipe[2:0], held >= tap_code_i};
	end
	assign cmp_ge_o = slow_i ? pipe[3] : pipe[0];
endmodule

/* File: verification/sac_top_test.sv */
// Self-checking bench for the converter control and its register slave.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "sac_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module sac_top_test;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cmp, slow = 0;
	logic [19:0] adr = 0;
	logic [3:0] sel = 4'h1;
	logic [31:0] dat = 0, q;
	logic [9:0] level = 0;
	int err_count = 0, checked = 0, cycles = 0;
	wire logic [31:0] dat_o;
	wire logic ack_o, sh, irq, pext, pint, mext;
	wire logic [9:0] tap;
	wire logic [7:0] pce;
	wire logic [3:0] asel, pfree;
	sac_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.cmp_ge_i(cmp), .sample_hold_o(sh), .tap_code_o(tap), .plus_ref_external_o(pext),
		.plus_ref_internal_o(pint), .minus_ref_external_o(mext),
		.periph_clock_enable_o(pce), .analog_select_o(asel), .port_free_o(pfree),
		.conversion_done_irq_o(irq));
	sac_front_end_model fe (.clk_i(clk_i), .sample_hold_i(sh), .tap_code_i(tap),
		.level_i(level), .slow_i(slow), .cmp_ge_o(cmp));
	always #2.5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			summarize();
		end
	end
	// Entered just after a rising edge; leaves one idle cycle behind
	task automatic wb(input logic w, input logic [19:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		q = dat_o;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [19:0] a, input logic [31:0] e);
		wb(0, a, 0);
		`CHK(q, e)
	endtask
	task automatic wait_for(input int which, input logic v);
		int n;
		n = 0;
		while ((which == 0 ? sh : irq) !== v && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 400) err_count++;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(`SAC_OFS_PER_EN, 0);
		`CHK(pce, 8'h00)
		wb(1, `SAC_OFS_MODE3, 32'hf);
		rd(`SAC_OFS_MODE3, 0);
		rd(`SAC_OFS_WIDE, 0);
		$display("test reset done");
	endtask
	task automatic t_enable();
		sel <= 4'h0;
		wb(1, `SAC_OFS_PER_EN, 32'h20);
		sel <= 4'h1;
		rd(`SAC_OFS_PER_EN, 0);
		wb(1, `SAC_OFS_PER_EN, 32'h20);
		rd(`SAC_OFS_PER_EN, 32'h20);
		`CHK(pce, 8'h20)
		wb(1, `SAC_OFS_MODE3, 32'h5);
		rd(`SAC_OFS_MODE3, 32'h5);
		rd(20'hf01fc, 0);
		$display("test enable done");
	endtask
	task automatic t_refs();
		for (int i = 0; i < 16; i++) begin
			wb(1, `SAC_OFS_MODE3, i);
			`CHK(pext, 1'(i[3] & i[2]))
			`CHK(pint, 1'(!i[3] & i[2]))
			`CHK(mext, 1'(i[1]))
		end
		$display("test refs done");
	endtask
	task automatic t_ports();
		wb(1, `SAC_OFS_CHAN, 32'h2);
		wb(1, `SAC_OFS_APC, 32'hf);
		`CHK(asel, 4'h4)
		`CHK(pfree, 4'hb)
		$display("test ports done");
	endtask
	task automatic convert(input logic res8, input logic [9:0] lv, input logic sl);
		logic [9:0] e;
		e = res8 ? {lv[9:2], 2'b00} : lv;
		level <= lv;
		slow <= sl;
		wb(1, `SAC_OFS_MODE3, {31'h0, res8});
		wb(1, `SAC_OFS_CTRL, 32'h3);
		wait_for(0, 1);
		wait_for(0, 0);
		repeat (3) @(posedge clk_i);
		`CHK(tap, 10'h200)
		repeat (10) @(posedge clk_i);
		`CHK(tap, lv[9] ? 10'h300 : 10'h100)
		wait_for(1, 1);
		@(posedge clk_i);
		`CHK(irq, 1'b0)
		rd(`SAC_OFS_WIDE, {16'h0, e, 6'h0});
		rd(`SAC_OFS_NARROW, {24'h0, e[9:2]});
		rd(`SAC_OFS_CTRL, 32'h2);
		rd(`SAC_OFS_STATUS, {18'h0, e, 4'h0});
		$display("test convert %h done", lv);
	endtask
	// Turning the clock off mid-run must scrap the conversion and results
	task automatic t_off();
		wb(1, `SAC_OFS_CTRL, 32'h1);
		repeat (40) @(posedge clk_i);
		wb(1, `SAC_OFS_PER_EN, 32'h0);
		`CHK(sh, 1'b0)
		`CHK(tap, 10'h000)
		`CHK(pce, 8'h00)
		rd(`SAC_OFS_APC, 32'hf);
		rd(`SAC_OFS_CTRL, 0);
		`CHK(asel, 4'h0)
		`CHK(pfree, 4'hf)
		wb(1, `SAC_OFS_MODE3, 32'h1);
		wb(1, `SAC_OFS_PER_EN, 32'h20);
		rd(`SAC_OFS_WIDE, 0);
		rd(`SAC_OFS_CTRL, 0);
		rd(`SAC_OFS_MODE3, 0);
		$display("test off done");
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		t_reset();
		t_enable();
		t_refs();
		t_ports();
		convert(0, 10'h2a5, 0);
		convert(0, 10'h200, 1);
		convert(1, 10'h1ff, 0);
		convert(0, 10'h0ff, 1);
		t_off();
		summarize();
	end
endmodule
